// *** tb/fault_detect_shutdown_bench.sv ***
/*
 * self-checking bench: ahb-lite master tasks, a pin model, fault scenarios.
 * assumes one slave, so hready is the slave's hreadyout.
 */
module fault_detect_shutdown_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------
	// signals and model state
	// ------------------------------------------------
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, irq;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, hready;
	logic kbi, cmp0, cmp1, mt0, mt1, pwt, fpin, dbg;
	logic [7:0] req = 8'h00, nout, noe, pin_out, pin_oe;
	int fails = 0, n_tests = 0, seed = 20, ch;
	int unit_m, flag_m, src_m, ine_m, pe_m, pd_m, pv_m; // model of the block
	always #10 hclk = ~hclk;
	assign hready = hreadyout;
	fault_source_model src (.hclk(hclk), .hresetn(hresetn), .fault_req(req),
		.kbi_irq(kbi), .cmp0_irq(cmp0), .cmp1_out(cmp1), .mtim0_irq(mt0),
		.mtim1_irq(mt1), .pwt_ready(pwt), .fault_pin(fpin), .debug_active(dbg),
		.normal_out(nout), .normal_oe(noe));
	fault_shutdown dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.kbi_irq(kbi), .cmp0_irq(cmp0), .cmp1_out(cmp1), .mtim0_irq(mt0),
		.mtim1_irq(mt1), .pwt_ready(pwt), .fault_pin(fpin), .debug_active(dbg),
		.normal_out(nout), .normal_oe(noe), .pin_out(pin_out), .pin_oe(pin_oe),
		.irq(irq));
	// ------------------------------------------------
	// checking and closing
	// ------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// pins at mid cycle against the model; levels of pins released by the override are not compared
	task automatic chk_pins;
		logic [7:0] o, e, m;
		logic act;
		@(negedge hclk);
		act = unit_m != 0 && (flag_m != 0 || (src_m & ine_m) != 0);
		for (int i = 0; i < 8; i++) begin
			o[i] = (act && pe_m[i]) ? pv_m[i] : nout[i];
			e[i] = (act && pe_m[i]) ? pd_m[i] : noe[i];
			m[i] = !(act && pe_m[i] && !pd_m[i]);
		end
		chk({16'h0, pin_oe, pin_out & m}, {16'h0, e, o & m}, "pins");
		@(posedge hclk);
	endtask
	// interrupt level at mid cycle, after register writes have settled
	task automatic chk_lvl(input logic exp, input string what);
		@(negedge hclk);
		chk({31'h0, irq}, {31'h0, exp}, what);
		@(posedge hclk);
	endtask
	// ------------------------------------------------
	// ahb-lite master, entered just after a rising edge
	// ------------------------------------------------
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int k;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		hsel <= 1'b1;
		rd = 32'h0;
		// address phase, then data phase; each ends at an edge with hready high
		for (int ph = 0; ph < 2; ph++) begin
			k = 0;
			do begin
				@(posedge hclk);
				k++;
			end while (hready !== 1'b1 && k < 50);
			if (hready !== 1'b1) begin
				fails++;
				final_report();
			end
			if (ph == 0) begin
				htrans <= 2'h0;
				hsel <= 1'b0;
				hwdata <= wd;
			end else begin
				// read data taken at the edge that ends the data phase
				rd = hrdata;
			end
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, exp, "register read");
		chk({31'h0, hresp}, 32'h0, "response");
	endtask
	// random pin set-up, written to the block and the model
	task automatic setpins;
		pe_m = $random(seed) & 8'hff;
		pd_m = $random(seed) & 8'hff;
		pv_m = $random(seed) & 8'hff;
		wr(8'h0c, pe_m);
		wr(8'h10, pd_m);
		wr(8'h14, pv_m);
	endtask
	// watchdog on the whole run
	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		final_report();
	end
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		{unit_m, flag_m, src_m, ine_m, pe_m, pd_m, pv_m} = '0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(8'h00, 32'h0);
		wr(8'h40, 32'hffffffff);
		rdc(8'h40, 32'h0);
		$display("test reset and unmapped done");
		// every channel but the comparator one
		for (ch = 0; ch < 8; ch++) begin
			if (ch == 2) continue;
			setpins();
			ine_m = 1 << ch;
			wr(8'h04, ine_m);
			wr(8'h00, 32'h4);
			unit_m = 1;
			req <= 8'h01 << ch;
			src_m = ine_m;
			flag_m = 1;
			chk_pins();
			req <= 8'h00;
			src_m = 0;
			chk_pins();
			rdc(8'h08, ine_m);
			rdc(8'h00, 32'h5);
			wr(8'h08, ine_m);
			chk_pins();
			wr(8'h00, 32'h4);
			flag_m = 0;
			chk_pins();
		end
		$display("test channels done");
		rdc(8'h1c, 32'h5);
		wr(8'h24, 32'h4);
		chk_lvl(1'b1, "irq on");
		wr(8'h20, 32'h7);
		chk_lvl(1'b0, "irq off");
		rdc(8'h1c, 32'h0);
		wr(8'h24, 32'h0);
		// force with fault interrupt enabled
		setpins();
		wr(8'h00, 32'he);
		flag_m = 1;
		chk_pins();
		chk_lvl(1'b1, "fault irq");
		wr(8'h00, 32'h4);
		flag_m = 0;
		chk_pins();
		chk_lvl(1'b0, "fault irq off");
		$display("test force and irq done");
		// unit off, then channel off
		wr(8'h00, 32'h0);
		unit_m = 0;
		wr(8'h04, 32'hff);
		ine_m = 8'hff;
		req <= 8'h40;
		src_m = 8'h40;
		chk_pins();
		req <= 8'h00;
		src_m = 0;
		rdc(8'h00, 32'h0);
		wr(8'h04, 32'hbf);
		ine_m = 8'hbf;
		wr(8'h00, 32'h4);
		unit_m = 1;
		req <= 8'h40;
		chk_pins();
		req <= 8'h00;
		rdc(8'h00, 32'h4);
		$display("test enables done");
		// comparator both edges into channel two, irq enabled
		wr(8'h04, 32'h4);
		ine_m = 4;
		wr(8'h18, 32'h7);
		req <= 8'h04;
		repeat (2) @(posedge hclk);
		src_m = 4;
		flag_m = 1;
		chk_pins();
		rdc(8'h18, 32'hf);
		wr(8'h18, 32'hf);
		src_m = 0;
		wr(8'h00, 32'h4);
		flag_m = 0;
		chk_pins();
		req <= 8'h00;
		repeat (3) @(posedge hclk);
		rdc(8'h18, 32'hf);
		rdc(8'h00, 32'h5);
		wr(8'h18, 32'hb);
		wr(8'h00, 32'h4);
		// comparator interrupt disabled gives no fault
		req <= 8'h04;
		repeat (3) @(posedge hclk);
		rdc(8'h00, 32'h4);
		chk_pins();
		rdc(8'h1c, 32'h7);
		$display("test comparator done");
		final_report();
	end
endmodule

// *** tb/fault_source_model.sv ***
/*
 * partner model: the fault sources and the timer pwm behind the pins.
 * assumes the bench raises faults through fault_req, synchronous to hclk.
 */
module fault_source_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// fault requests from the bench
	input wire logic [7:0] fault_req,
	// fault sources
	output logic kbi_irq,
	output logic cmp0_irq,
	output logic cmp1_out,
	output logic mtim0_irq,
	output logic mtim1_irq,
	output logic pwt_ready,
	output logic fault_pin,
	output logic debug_active,
	// timer side of the pins
	output logic [7:0] normal_out,
	output logic [7:0] normal_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] pwm_q; // pwm pattern, new value every cycle
	// ------------------------------------------------
	// source per channel
	// ------------------------------------------------
	// fixed channel sources
	assign kbi_irq = fault_req[0];
	assign cmp0_irq = fault_req[1];
	assign mtim0_irq = fault_req[3];
	assign mtim1_irq = fault_req[4];
	assign pwt_ready = fault_req[5];
	assign fault_pin = fault_req[6];
	assign debug_active = fault_req[7];
	// comparator level, its edges feed channel two
	assign cmp1_out = fault_req[2];
	// pwm and enables move every cycle so a stale pass-through shows
	assign normal_out = pwm_q;
	assign normal_oe = ~{pwm_q[3:0], pwm_q[7:4]};
	// pattern counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_q <= 8'h00;
		end else begin
			pwm_q <= pwm_q + 8'h35;
		end
	end
endmodule

// *** verilog/fault_shutdown.sv ***
/*
 * fault detect and shutdown: eight fault channels, eight controlled
 * pins, a comparator edge flag for channel two and an ahb-lite slave.
 * assumes all fault inputs are synchronous to hclk and one-cycle
 * reads with zero wait states are acceptable to the master.
 */
module fault_shutdown (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// fault sources
	input wire logic kbi_irq,
	input wire logic cmp0_irq,
	input wire logic cmp1_out,
	input wire logic mtim0_irq,
	input wire logic mtim1_irq,
	input wire logic pwt_ready,
	input wire logic fault_pin,
	input wire logic debug_active,
	// controlled pins
	input wire logic [7:0] normal_out,
	input wire logic [7:0] normal_oe,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	// interrupt
	output logic irq
);
	// --------------------------------------------------------------
	// bus slave
	// --------------------------------------------------------------
	logic wr_q; // data phase of a write
	logic [7:0] addr_q; // registered byte offset
	wire take = hsel & hready & htrans[1]; // valid address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			addr_q <= 8'h00;
		end else if (hready) begin
			wr_q <= take & hwrite;
			addr_q <= take ? haddr[7:0] : 8'h00;
		end
	end
	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// write strobes per register
	wire wr_ctrl = wr_q & (addr_q == shutdown_pkg::ctrl_status_off);
	wire wr_ine = wr_q & (addr_q == shutdown_pkg::input_enable_off);
	wire wr_inl = wr_q & (addr_q == shutdown_pkg::input_latch_off);
	wire wr_pce = wr_q & (addr_q == shutdown_pkg::pin_enable_off);
	wire wr_pcd = wr_q & (addr_q == shutdown_pkg::pin_direction_off);
	wire wr_pcv = wr_q & (addr_q == shutdown_pkg::pin_value_off);
	wire wr_cmp = wr_q & (addr_q == shutdown_pkg::comparator_ctrl_off);
	wire wr_iclr = wr_q & (addr_q == shutdown_pkg::irq_clear_off);
	wire wr_ien = wr_q & (addr_q == shutdown_pkg::irq_enable_off);
	// --------------------------------------------------------------
	// configuration registers
	// --------------------------------------------------------------
	logic [7:0] fault_input_enable_reg; // per-channel enables
	logic [7:0] pin_override_enable_reg; // per-pin takeover
	logic [7:0] pin_override_direction_reg; // 1 drive, 0 release
	logic [7:0] pin_override_value_reg; // driven level
	logic fault_irq_enable; // flag to interrupt
	logic shutdown_unit_enable; // global enable
	logic [1:0] comparator_irq_edge_mode; // edge select
	logic cmp_irq_enable; // comparator interrupt enable
	logic [shutdown_pkg::num_events-1:0] irq_enable_q; // event mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_input_enable_reg <= shutdown_pkg::byte_reset;
			pin_override_enable_reg <= shutdown_pkg::byte_reset;
			pin_override_direction_reg <= shutdown_pkg::byte_reset;
			pin_override_value_reg <= shutdown_pkg::byte_reset;
			fault_irq_enable <= 1'b0;
			shutdown_unit_enable <= 1'b0;
			comparator_irq_edge_mode <= 2'h0;
			cmp_irq_enable <= 1'b0;
			irq_enable_q <= '0;
		end else begin
			if (wr_ine) fault_input_enable_reg <= hwdata[7:0];
			if (wr_pce) pin_override_enable_reg <= hwdata[7:0];
			if (wr_pcd) pin_override_direction_reg <= hwdata[7:0];
			if (wr_pcv) pin_override_value_reg <= hwdata[7:0];
			if (wr_ctrl) begin
				fault_irq_enable <= hwdata[shutdown_pkg::irq_en_bit];
				shutdown_unit_enable <= hwdata[shutdown_pkg::unit_en_bit];
			end
			if (wr_cmp) begin
				comparator_irq_edge_mode <= hwdata[shutdown_pkg::cmp_mode_lsb +: 2];
				cmp_irq_enable <= hwdata[shutdown_pkg::cmp_irq_en_bit];
			end
			if (wr_ien) irq_enable_q <= hwdata[shutdown_pkg::num_events-1:0];
		end
	end
	// --------------------------------------------------------------
	// second comparator interrupt
	// --------------------------------------------------------------
	logic cmp_prev_q; // comparator output one cycle ago
	logic comparator_irq_flag; // sticky edge flag
	wire cmp_rise = cmp1_out & ~cmp_prev_q;
	wire cmp_fall = ~cmp1_out & cmp_prev_q;
	wire cmp_edge = (comparator_irq_edge_mode == shutdown_pkg::cmp_mode_both) ?
		(cmp_rise | cmp_fall) :
		((comparator_irq_edge_mode == shutdown_pkg::cmp_mode_rise) ? cmp_rise : cmp_fall);
	// write 1 to the flag bit clears it; a new edge wins
	wire cmp_flag_clr = wr_cmp & hwdata[shutdown_pkg::cmp_flag_bit];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_prev_q <= 1'b0;
			comparator_irq_flag <= 1'b0;
		end else begin
			cmp_prev_q <= cmp1_out;
			comparator_irq_flag <= cmp_edge | (comparator_irq_flag & ~cmp_flag_clr);
		end
	end
	// no fault unless software enables it
	wire cmp1_irq = comparator_irq_flag & cmp_irq_enable;
	// --------------------------------------------------------------
	// fault channels
	// --------------------------------------------------------------
	logic [7:0] fault_in_channel; // raw sources by channel
	assign fault_in_channel = {debug_active, fault_pin, pwt_ready, mtim1_irq,
		mtim0_irq, cmp1_irq, cmp0_irq, kbi_irq};
	wire fault_in_channel_two = fault_in_channel[shutdown_pkg::cmp1_channel];
	wire [7:0] chan_active = fault_in_channel & fault_input_enable_reg &
		{8{shutdown_unit_enable}};
	wire any_active = |chan_active;
	wire force_wr = wr_ctrl & hwdata[shutdown_pkg::force_bit];
	// --------------------------------------------------------------
	// flag and latch
	// --------------------------------------------------------------
	logic [7:0] fault_input_latch_reg; // sticky per-channel record
	logic fault_flag; // sticky global flag
	// flag clears on a write of 0, latch bits on a write of 1
	wire flag_clr = wr_ctrl & ~hwdata[shutdown_pkg::flag_bit];
	wire [7:0] latch_clr = wr_inl ? hwdata[7:0] : 8'h00;
	wire flag_set = any_active | force_wr;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_input_latch_reg <= shutdown_pkg::byte_reset;
			fault_flag <= 1'b0;
		end else begin
			fault_input_latch_reg <= chan_active | (fault_input_latch_reg & ~latch_clr);
			fault_flag <= flag_set | (fault_flag & ~flag_clr);
		end
	end
	// --------------------------------------------------------------
	// pin override
	// --------------------------------------------------------------
	// same-cycle path from source
	// held while flag set or source live
	wire override = shutdown_unit_enable & (any_active | fault_flag | force_wr);
	genvar gi;
	generate
		for (gi = 0; gi < shutdown_pkg::num_channels; gi++) begin : g_pin
			pin_override_cell u_cell (
				.normal_out(normal_out[gi]),
				.normal_oe(normal_oe[gi]),
				.override(override),
				.pin_enable(pin_override_enable_reg[gi]),
				.pin_direction(pin_override_direction_reg[gi]),
				.pin_value(pin_override_value_reg[gi]),
				.pin_out(pin_out[gi]),
				.pin_oe(pin_oe[gi])
			);
		end
	endgenerate
	// --------------------------------------------------------------
	// interrupts
	// --------------------------------------------------------------
	logic override_q; // override one cycle ago
	logic [shutdown_pkg::num_events-1:0] irq_status_q; // sticky events
	wire [shutdown_pkg::num_events-1:0] ev_set = {override_q & ~override,
		cmp_edge, flag_set};
	wire [shutdown_pkg::num_events-1:0] ev_clr = wr_iclr ?
		hwdata[shutdown_pkg::num_events-1:0] : '0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			override_q <= 1'b0;
			irq_status_q <= '0;
		end else begin
			override_q <= override;
			irq_status_q <= ev_set | (irq_status_q & ~ev_clr);
		end
	end
	assign irq = (fault_flag & fault_irq_enable) | (|(irq_status_q & irq_enable_q));
	// --------------------------------------------------------------
	// read mux
	// --------------------------------------------------------------
	wire [31:0] ctrl_word = {28'h0, 1'b0, shutdown_unit_enable, fault_irq_enable,
		fault_flag};
	wire [31:0] cmp_word = {28'h0, comparator_irq_flag, cmp_irq_enable,
		comparator_irq_edge_mode};
	always_comb begin
		unique case (addr_q)
			shutdown_pkg::ctrl_status_off: hrdata = ctrl_word;
			shutdown_pkg::input_enable_off: hrdata = {24'h0, fault_input_enable_reg};
			shutdown_pkg::input_latch_off: hrdata = {24'h0, fault_input_latch_reg};
			shutdown_pkg::pin_enable_off: hrdata = {24'h0, pin_override_enable_reg};
			shutdown_pkg::pin_direction_off: hrdata = {24'h0, pin_override_direction_reg};
			shutdown_pkg::pin_value_off: hrdata = {24'h0, pin_override_value_reg};
			shutdown_pkg::comparator_ctrl_off: hrdata = cmp_word;
			shutdown_pkg::irq_status_off: hrdata = {29'h0, irq_status_q};
			shutdown_pkg::irq_enable_off: hrdata = {29'h0, irq_enable_q};
			// unmapped and write-only offsets read zero
			default: hrdata = 32'h0;
		endcase
	end
	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_global_gate: assert property (!shutdown_unit_enable |-> chan_active == 8'h00)
		else $error("fault channel active while unit disabled");
	a_latch_capture: assert property (any_active |=> fault_flag &&
		((fault_input_latch_reg & $past(chan_active)) == $past(chan_active)))
		else $error("active channel not latched");
	a_forced_pins: assert property (override |-> ((pin_oe ^ pin_override_direction_reg) &
		pin_override_enable_reg) == 8'h00 && ((pin_out ^ (pin_override_direction_reg &
		pin_override_value_reg)) & pin_override_enable_reg) == 8'h00)
		else $error("forced pin state wrong");
	a_bypass_pins: assert property ((((pin_out ^ normal_out) | (pin_oe ^ normal_oe)) &
		~pin_override_enable_reg) == 8'h00)
		else $error("bypassed pin altered");
	a_hold_override: assert property (fault_flag && shutdown_unit_enable |-> override)
		else $error("override dropped with flag set");
	a_same_cycle: assert property (any_active |-> override)
		else $error("override late");
	a_chan_two: assert property (fault_in_channel_two == (comparator_irq_flag &&
		cmp_irq_enable))
		else $error("channel two not comparator");
	a_both_edges: assert property (comparator_irq_edge_mode == shutdown_pkg::cmp_mode_both &&
		cmp1_out != $past(cmp1_out) |=> comparator_irq_flag)
		else $error("comparator edge missed");
	a_force_fault: assert property (force_wr && shutdown_unit_enable |-> override ##1 fault_flag)
		else $error("force did not fault");
	a_irq_request: assert property (fault_flag && fault_irq_enable |-> irq)
		else $error("fault irq missing");
	a_flag_sticky: assert property (fault_flag && !flag_clr |=> fault_flag)
		else $error("flag cleared by itself");
	a_latch_sticky: assert property (!wr_inl |=>
		(fault_input_latch_reg & $past(fault_input_latch_reg)) ==
		$past(fault_input_latch_reg))
		else $error("latch bit cleared by itself");
	c_override_on: cover property (!override ##1 override);
	c_release: cover property (override ##1 !override);
	c_forced: cover property (force_wr);
	c_cmp_fault: cover property (fault_in_channel_two && fault_input_enable_reg[2]);
endmodule

// *** verilog/pin_override_cell.sv ***
/*
 * one controlled pin: passes the normal function or forces the pin.
 * assumes override is already qualified by the unit enable.
 */
module pin_override_cell (
	// normal function from the timer or port
	input wire logic normal_out,
	input wire logic normal_oe,
	// override controls
	input wire logic override,
	input wire logic pin_enable,
	input wire logic pin_direction,
	input wire logic pin_value,
	// pin side
	output logic pin_out,
	output logic pin_oe
);
	// this pin is taken over by the shutdown logic
	wire forced = override & pin_enable;
	assign pin_oe = forced ? pin_direction : normal_oe;
	assign pin_out = forced ? (pin_direction & pin_value) : normal_out;
endmodule

// *** verilog/shutdown_pkg.sv ***
/*
 * constants for the fault detect and shutdown block: register offsets,
 * field positions, reset values and channel numbers.
 * assumes a 32-bit ahb-lite bus with word-aligned registers.
 */
// Notes on behaviour
// - act only with channel and global enable
// - enabled fault latches its bit, sets flag
// - enabled pin driven 1, 0 or released
// - pin with enable clear passes normal function
// - hold override until source gone, flag cleared
// - fault reaches pins within one clock
// - second comparator interrupt feeds channel two
// - edge mode three flags both edges
// - fixed source for each of eight channels
// - writing force bit makes a fault
// - direction picks drive, value picks level
// - irq enable gates flag onto interrupt
package shutdown_pkg;
	// --------------------------------------------------------------
	// register byte offsets
	// --------------------------------------------------------------
	localparam logic [7:0] ctrl_status_off = 8'h00;
	localparam logic [7:0] input_enable_off = 8'h04;
	localparam logic [7:0] input_latch_off = 8'h08;
	localparam logic [7:0] pin_enable_off = 8'h0c;
	localparam logic [7:0] pin_direction_off = 8'h10;
	localparam logic [7:0] pin_value_off = 8'h14;
	localparam logic [7:0] comparator_ctrl_off = 8'h18;
	localparam logic [7:0] irq_status_off = 8'h1c;
	localparam logic [7:0] irq_clear_off = 8'h20;
	localparam logic [7:0] irq_enable_off = 8'h24;
	// --------------------------------------------------------------
	// control and status fields
	// --------------------------------------------------------------
	localparam int flag_bit = 0;
	localparam int irq_en_bit = 1;
	localparam int unit_en_bit = 2;
	localparam int force_bit = 3;
	// comparator control fields
	localparam int cmp_mode_lsb = 0;
	localparam int cmp_irq_en_bit = 2;
	localparam int cmp_flag_bit = 3;
	localparam logic [1:0] cmp_mode_both = 2'h3;
	localparam logic [1:0] cmp_mode_rise = 2'h1;
	// interrupt status bits
	localparam int ev_fault_bit = 0;
	localparam int ev_cmp_bit = 1;
	localparam int ev_release_bit = 2;
	localparam int num_events = 3;
	// --------------------------------------------------------------
	// channels and reset values
	// --------------------------------------------------------------
	localparam int num_channels = 8;
	localparam int cmp1_channel = 2;
	localparam logic [7:0] byte_reset = 8'h00;
endpackage
